// >>> hw/beacon_byte_shifter.sv
// byte shifter: sends a loaded vector out lowest byte first with valid/ready
module beacon_byte_shifter #(
  parameter int NBYTES = 13
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire logic [NBYTES*8-1:0]   vec_i,
  input  wire logic                  ready_i,
  output beacon_pkg::tx_beat_s       beat_o,
  output logic                       valid_o,
  output logic                       busy_o
);

  beacon_pkg::shift_state_e state_q;
  logic [NBYTES*8-1:0]      shreg_q;
  logic [7:0]               left_q;

  // a beat moves when the far side takes it
  wire logic take = valid_o & ready_i;
  wire logic done = take & beat_o.last;

  assign busy_o = (state_q == beacon_pkg::SHIFT_BUSY);

  // start is ignored while a frame is in flight, so fields never mix
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= beacon_pkg::SHIFT_IDLE;
      shreg_q <= '0;
      left_q  <= 8'h00;
      valid_o <= 1'b0;
      beat_o  <= '0;
    end else begin
      unique case (state_q)
        beacon_pkg::SHIFT_IDLE: begin
          if (start_i) begin
            state_q     <= beacon_pkg::SHIFT_BUSY;
            beat_o.data <= vec_i[7:0];
            beat_o.last <= (NBYTES == 1);
            shreg_q     <= vec_i >> 8;
            left_q      <= 8'(NBYTES - 1);
            valid_o     <= 1'b1;
          end
        end
        beacon_pkg::SHIFT_BUSY: begin
          if (done) begin
            state_q <= beacon_pkg::SHIFT_IDLE;
            valid_o <= 1'b0;
            beat_o  <= '0;
          end else if (take) begin
            beat_o.data <= shreg_q[7:0];
            beat_o.last <= (left_q == 8'h01);
            shreg_q     <= shreg_q >> 8;
            left_q      <= left_q - 8'h01;
          end
        end
      endcase
    end
  end

endmodule // beacon_byte_shifter

// >>> hw/beacon_cfg.svh
// offsets, field layouts, reset values and fixed field codes of the beacon builder
`ifndef BEACON_CFG_SVH
`define BEACON_CFG_SVH

// register byte offsets on the plain register port
`define BFB_OFF_CTRL        5'h00
`define BFB_OFF_PAN_ID      5'h04
`define BFB_OFF_SHORT_ADDR  5'h08
`define BFB_OFF_MAX_HOPS    5'h0C
`define BFB_OFF_COST        5'h10
`define BFB_OFF_SEQ         5'h14
`define BFB_OFF_STATUS      5'h18

// control register bits
`define BFB_CTRL_COORD_BIT  0
`define BFB_CTRL_PERMIT_BIT 1

// status register bits
`define BFB_STAT_BUSY_BIT   0
`define BFB_STAT_MAXH_BIT   1

// reset values
`define BFB_CTRL_RST        2'h0
`define BFB_PAN_ID_RST      16'hFFFF
`define BFB_SHORT_ADDR_RST  16'hFFFF
`define BFB_SEQ_RST         8'h00
`define BFB_COST_RST        16'hFFFF

// coordinator route cost fixed values
`define BFB_COST_FAIL       16'hFFFF
`define BFB_COST_INIT       16'h7FFF
`define BFB_COST_COORD      16'h0000

// beacon frame control: type beacon, source short, version bits 13:12 kept zero
`define BFB_FC_BEACON       16'h8000
`define BFB_FC_TYPE_MSB     2
`define BFB_FC_TYPE_BEACON  3'h0

// superframe field positions; all timing subfields stay zero
`define BFB_SF_PANC_BIT     14
`define BFB_SF_PERMIT_BIT   15
`define BFB_GTS_SPEC        8'h00
`define BFB_PEND_SPEC       8'h00

// beacon length in bytes, MAC header plus beacon fields
`define BFB_BEACON_BYTES    13

`endif

// >>> hw/beacon_field_builder.sv
// beacon field builder: route cost keeper, beacon byte stream, ack request, rx frame check
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`include "beacon_cfg.svh"

// How it works
// - pending address counts both sent as zero
// - no pending address list follows its spec
// - GTS list absent, zero bytes in beacon
// - two-byte route cost payload, high byte first
// - cost tracks lowest coordinator-originated cost seen
// - communication failure sets cost to all ones
// - association or max hops loads initial cost
// - coordinator role holds cost at zero
// - frame version reserved, ignored on receive
// - beacon, superframe order, final slot, battery zero
// - GTS descriptor count and permit zero
// - GTS direction field never present
module beacon_field_builder #(
  parameter logic [3:0] MAX_HOPS_DEFAULT = 4'h8
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  // register port
  input  wire logic [4:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O,
  // route cost events
  input  wire logic        COORD_FAIL_I,
  input  wire logic        ASSOC_I,
  input  wire logic [3:0]  HOP_COUNT_I,
  input  wire logic        OBS_COST_VALID_I,
  input  wire logic [15:0] OBS_COST_I,
  // beacon byte stream
  input  wire logic        BEACON_REQ_I,
  input  wire logic        TX_READY_I,
  output logic             TX_VALID_O,
  output logic [7:0]       TX_BYTE_O,
  output logic             TX_LAST_O,
  // acknowledgement
  input  wire logic        ACK_NEEDED_I,
  output logic             PHY_ACK_REQ_O,
  // received frame control check
  input  wire logic        RX_FC_VALID_I,
  input  wire logic [15:0] RX_FC_I,
  output logic             RX_IS_BEACON_O,
  output logic             RX_FC_DONE_O,
  // current cost for other blocks
  output logic [15:0]      COORD_COST_O
);

  // ---------------- registers ----------------
  logic [1:0]          ctrl_q;
  logic [15:0]         pan_id_q;
  logic [15:0]         short_addr_q;
  logic [3:0]          max_hop_limit_q;
  logic [7:0]          seq_q;
  beacon_pkg::cost_t   coordinator_route_cost_q;
  beacon_pkg::cost_t   coordinator_route_cost_d;
  beacon_pkg::cost_evt_s evt;

  // write decode
  wire logic wr_ctrl  = REG_WR_I & (REG_ADDR_I == `BFB_OFF_CTRL);
  wire logic wr_pan   = REG_WR_I & (REG_ADDR_I == `BFB_OFF_PAN_ID);
  wire logic wr_short = REG_WR_I & (REG_ADDR_I == `BFB_OFF_SHORT_ADDR);
  wire logic wr_hops  = REG_WR_I & (REG_ADDR_I == `BFB_OFF_MAX_HOPS);
  wire logic wr_seq   = REG_WR_I & (REG_ADDR_I == `BFB_OFF_SEQ);

  wire logic is_coord     = ctrl_q[`BFB_CTRL_COORD_BIT];
  wire logic assoc_permit = ctrl_q[`BFB_CTRL_PERMIT_BIT];

  // hop level is held as long as the node sits at the hop limit
  wire logic at_max_hops = (HOP_COUNT_I == max_hop_limit_q);

  // route cost events gathered into one carrier with a single driver
  assign evt = '{fail:      COORD_FAIL_I,
                 assoc:     ASSOC_I,
                 obs_valid: OBS_COST_VALID_I,
                 obs_cost:  OBS_COST_I};

  // byte shifter handshake
  logic      shift_busy;
  wire logic beacon_start = BEACON_REQ_I & ~shift_busy;

  // ---------------- route cost keeper ----------------
  // priority: coordinator role, failure, reinit, then lower observed cost;
  // a computed cost from a full route calculation would enter as an observation
  wire logic obs_lower = evt.obs_valid & (evt.obs_cost < coordinator_route_cost_q);

  // one-hot load selects; equal costs are not taken, so a repeated
  // observation cannot keep rewriting the register
  wire logic load_coord = is_coord;
  wire logic load_fail  = ~is_coord & evt.fail;
  wire logic load_init  = ~is_coord & ~evt.fail & (evt.assoc | at_max_hops);
  wire logic load_obs   = ~is_coord & ~evt.fail & ~(evt.assoc | at_max_hops)
                          & obs_lower;

  always_comb begin
    coordinator_route_cost_d = coordinator_route_cost_q;
    if (load_coord) begin
      coordinator_route_cost_d = `BFB_COST_COORD;
    end else if (load_fail) begin
      coordinator_route_cost_d = `BFB_COST_FAIL;
    end else if (load_init) begin
      coordinator_route_cost_d = `BFB_COST_INIT;
    end else if (load_obs) begin
      coordinator_route_cost_d = evt.obs_cost;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      coordinator_route_cost_q <= `BFB_COST_RST;
    end else begin
      coordinator_route_cost_q <= coordinator_route_cost_d;
    end
  end

  // ---------------- configuration registers ----------------
  // role and permit bits; a role change reaches the cost one cycle later
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_q <= `BFB_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= REG_WDATA_I[1:0];
    end
  end

  // pan id, sent low byte first in the header
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      pan_id_q <= `BFB_PAN_ID_RST;
    end else if (wr_pan) begin
      pan_id_q <= REG_WDATA_I[15:0];
    end
  end

  // short source address, also low byte first
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      short_addr_q <= `BFB_SHORT_ADDR_RST;
    end else if (wr_short) begin
      short_addr_q <= REG_WDATA_I[15:0];
    end
  end

  // hop limit; only four bits are kept, upper data bits are dropped
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      max_hop_limit_q <= MAX_HOPS_DEFAULT;
    end else if (wr_hops) begin
      max_hop_limit_q <= REG_WDATA_I[3:0];
    end
  end

  // sequence number: a software write wins over the beacon increment
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      seq_q <= `BFB_SEQ_RST;
    end else if (wr_seq) begin
      seq_q <= REG_WDATA_I[7:0];
    end else if (beacon_start) begin
      seq_q <= seq_q + 8'h01;
    end
  end

  // ---------------- beacon field assembly ----------------
  // superframe spec: a beaconless network uses none of the timing
  // subfields, so only the coordinator and permit flags can be set
  wire logic [3:0] sf_beacon_order = 4'h0;
  wire logic [3:0] sf_frame_order  = 4'h0;
  wire logic [3:0] sf_final_slot   = 4'h0;
  wire logic       sf_battery_ext  = 1'b0;
  logic [15:0] superframe_spec;
  always_comb begin
    superframe_spec = {3'h0, sf_battery_ext, sf_final_slot,
                       sf_frame_order, sf_beacon_order};
    superframe_spec[`BFB_SF_PANC_BIT]   = is_coord;
    superframe_spec[`BFB_SF_PERMIT_BIT] = assoc_permit;
  end

  // frame control: beacon type, no destination, short source, no
  // security or ack request; version stays 0 because it is reserved
  wire logic [2:0]  fc_type     = `BFB_FC_TYPE_BEACON;
  wire logic [1:0]  fc_dst_mode = 2'h0;
  wire logic [1:0]  fc_version  = 2'h0;
  wire logic [1:0]  fc_src_mode = 2'h2;
  wire logic [15:0] frame_ctrl  = {fc_src_mode, fc_version, fc_dst_mode,
                                   3'h0, 4'h0, fc_type};

  // gts spec: count 0 and permit 0, so neither a direction byte nor a
  // list is appended; a peer never sees a slot it could request
  wire logic [2:0] gts_desc_count = 3'h0;
  wire logic       gts_permit     = 1'b0;
  wire logic [7:0] gts_spec = {gts_permit, 4'h0, gts_desc_count};

  // pending spec: indirect transmission is not offered, so both counts
  // are 0 and no address list follows
  wire logic [2:0] pend_short_count = 3'h0;
  wire logic [2:0] pend_ext_count   = 3'h0;
  wire logic [7:0] pend_spec = {1'b0, pend_ext_count, 1'b0, pend_short_count};

  // payload: route cost high byte ahead of low byte on the wire
  wire logic [15:0] payload_wire = {coordinator_route_cost_q[7:0],
                                    coordinator_route_cost_q[15:8]};

  // vector is sent lowest byte first; header fields are little endian
  wire logic [`BFB_BEACON_BYTES*8-1:0] beacon_vec = {
    payload_wire,
    pend_spec,
    gts_spec,
    superframe_spec,
    short_addr_q,
    pan_id_q,
    seq_q,
    frame_ctrl
  };

  beacon_pkg::tx_beat_s beat;

  beacon_byte_shifter #(
    .NBYTES (`BFB_BEACON_BYTES)
  ) u_shifter (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .start_i (beacon_start),
    .vec_i   (beacon_vec),
    .ready_i (TX_READY_I),
    .beat_o  (beat),
    .valid_o (TX_VALID_O),
    .busy_o  (shift_busy)
  );

  assign TX_BYTE_O = beat.data;
  assign TX_LAST_O = beat.last;

  // ---------------- acknowledgement ----------------
  // no ack frame is ever built; the phy primitive is raised one cycle after the request, for as long as it is held
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      PHY_ACK_REQ_O <= 1'b0;
    end else begin
      PHY_ACK_REQ_O <= ACK_NEEDED_I;
    end
  end

  // ---------------- receive frame control check ----------------
  // only the frame type is compared; version bits are masked off
  wire logic rx_type_beacon = (RX_FC_I[`BFB_FC_TYPE_MSB:0] == `BFB_FC_TYPE_BEACON);

  // done pulse one cycle after the field arrives
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      RX_FC_DONE_O <= 1'b0;
    end else begin
      RX_FC_DONE_O <= RX_FC_VALID_I;
    end
  end

  // type flag holds until the next checked frame so it can be read late
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      RX_IS_BEACON_O <= 1'b0;
    end else if (RX_FC_VALID_I) begin
      RX_IS_BEACON_O <= rx_type_beacon;
    end
  end

  // status flags at their own bit positions
  logic [1:0] status_bits;
  always_comb begin
    status_bits                     = 2'h0;
    status_bits[`BFB_STAT_BUSY_BIT] = shift_busy;
    status_bits[`BFB_STAT_MAXH_BIT] = at_max_hops;
  end

  // ---------------- register read ----------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (REG_ADDR_I)
      `BFB_OFF_CTRL:       rd_mux = {30'h0, ctrl_q};
      `BFB_OFF_PAN_ID:     rd_mux = {16'h0, pan_id_q};
      `BFB_OFF_SHORT_ADDR: rd_mux = {16'h0, short_addr_q};
      `BFB_OFF_MAX_HOPS:   rd_mux = {28'h0, max_hop_limit_q};
      `BFB_OFF_COST:       rd_mux = {16'h0, coordinator_route_cost_q};
      `BFB_OFF_SEQ:        rd_mux = {24'h0, seq_q};
      `BFB_OFF_STATUS:     rd_mux = {30'h0, status_bits};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rd_mux;
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  // cost mirrored to other blocks from its own flop
  assign COORD_COST_O = coordinator_route_cost_q;

endmodule // beacon_field_builder

// >>> hw/beacon_pkg.sv
// shared types of the beacon field builder
package beacon_pkg;

  typedef logic [15:0] cost_t;

  // one byte beat towards the frame transmitter
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tx_beat_s;

  // route cost events from the routing layer
  typedef struct packed {
    logic  fail;
    logic  assoc;
    logic  obs_valid;
    cost_t obs_cost;
  } cost_evt_s;

  typedef enum logic [0:0] {
    SHIFT_IDLE = 1'b0,
    SHIFT_BUSY = 1'b1
  } shift_state_e;

endpackage

// >>> verif/beacon_field_builder_assertions.sv
// port-level checks of the beacon field builder
`include "beacon_cfg.svh"
module beacon_field_builder_checker #(
  parameter logic [3:0] MAX_HOPS_DEFAULT = 4'h8
) (
  input wire logic        CLK_SYS_I,
  input wire logic        RESET_I,
  input wire logic [4:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        COORD_FAIL_I,
  input wire logic        ASSOC_I,
  input wire logic [3:0]  HOP_COUNT_I,
  input wire logic        OBS_COST_VALID_I,
  input wire logic [15:0] OBS_COST_I,
  input wire logic        TX_READY_I,
  input wire logic        TX_VALID_O,
  input wire logic [7:0]  TX_BYTE_O,
  input wire logic        TX_LAST_O,
  input wire logic        ACK_NEEDED_I,
  input wire logic        PHY_ACK_REQ_O,
  input wire logic        RX_FC_VALID_I,
  input wire logic [15:0] RX_FC_I,
  input wire logic        RX_IS_BEACON_O,
  input wire logic        RX_FC_DONE_O,
  input wire logic [15:0] COORD_COST_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       coord_q;
  logic [3:0] hops_q;
  logic [3:0] cnt_q;
  // shadows of role and hop limit, plus byte index within a beacon
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      coord_q <= 1'b0;
      hops_q  <= MAX_HOPS_DEFAULT;
      cnt_q   <= 4'h0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `BFB_OFF_CTRL) coord_q <= REG_WDATA_I[0];
      if (REG_WR_I && REG_ADDR_I == `BFB_OFF_MAX_HOPS) hops_q <= REG_WDATA_I[3:0];
      if (TX_VALID_O && TX_READY_I) cnt_q <= TX_LAST_O ? 4'h0 : cnt_q + 4'h1;
    end
  end
  // no higher-priority cost event this cycle
  wire at_max = HOP_COUNT_I == hops_q;
  wire quiet  = !coord_q && !COORD_FAIL_I && !ASSOC_I && !at_max;
  wire lower  = OBS_COST_VALID_I && OBS_COST_I < COORD_COST_O;
  wire fc_bcn = RX_FC_I[2:0] == 3'h0;
  default clocking dcb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  sequence ack_pulse_s;
    PHY_ACK_REQ_O ##1 !PHY_ACK_REQ_O;
  endsequence
  ack_pulse_a: assert property (ACK_NEEDED_I ##1 !ACK_NEEDED_I |-> ack_pulse_s)
    else $error("ack pulse wrong");
  ack_cause_a: assert property (PHY_ACK_REQ_O |-> $past(ACK_NEEDED_I))
    else $error("ack without cause");
  coord_zero_a: assert property (coord_q |=> COORD_COST_O == 16'h0000)
    else $error("coordinator cost not zero");
  fail_max_a: assert property (COORD_FAIL_I && !coord_q |=> COORD_COST_O == 16'hFFFF)
    else $error("fail cost wrong");
  init_cost_a: assert property ((ASSOC_I || at_max) && !COORD_FAIL_I && !coord_q
    |=> COORD_COST_O == 16'h7FFF) else $error("initial cost wrong");
  obs_lower_a: assert property (quiet && lower |=> COORD_COST_O == $past(OBS_COST_I))
    else $error("lower cost not taken");
  cost_hold_a: assert property (quiet && !lower |=> $stable(COORD_COST_O))
    else $error("cost moved");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I
    |=> TX_VALID_O && $stable(TX_BYTE_O) && $stable(TX_LAST_O)) else $error("byte dropped");
  zero_spec_a: assert property (TX_VALID_O && cnt_q inside {4'h7, 4'h9, 4'hA}
    |-> TX_BYTE_O == 8'h00) else $error("spec byte not zero");
  sf_high_a: assert property (TX_VALID_O && cnt_q == 4'h8 |-> TX_BYTE_O[5:0] == 6'h00)
    else $error("superframe high wrong");
  frame_len_a: assert property (TX_VALID_O |-> TX_LAST_O == (cnt_q == 4'hC))
    else $error("beacon length wrong");
  rx_type_a: assert property (RX_FC_VALID_I
    |=> RX_FC_DONE_O && RX_IS_BEACON_O == $past(fc_bcn)) else $error("rx type wrong");
endmodule // beacon_field_builder_checker
bind beacon_field_builder beacon_field_builder_checker #(
  .MAX_HOPS_DEFAULT(MAX_HOPS_DEFAULT)
) u_beacon_field_builder_checker (.*);

// >>> verif/beacon_sink_model.sv
// peer node receiving beacon bytes, with an optional stalling ready
module beacon_sink_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         stall_i,
  input  wire logic         valid_i,
  input  wire logic [7:0]   byte_i,
  input  wire logic         last_i,
  output logic              ready_o,
  output logic [103:0]      frame_o,
  output logic [7:0]        frames_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] idx_q;
  // version bits are not looked at, bytes are stored as they come
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o  <= 1'b0;
      frame_o  <= '0;
      frames_o <= 8'h00;
      idx_q    <= 4'h0;
    end else begin
      ready_o <= stall_i ? !ready_o : 1'b1;
      if (valid_i && ready_o) begin
        frame_o[idx_q*8 +: 8] <= byte_i;
        idx_q <= last_i ? 4'h0 : idx_q + 4'h1;
        if (last_i) frames_o <= frames_o + 8'h01;
      end
    end
  end
endmodule // beacon_sink_model

// >>> verif/test_beacon_field_builder.sv
// self-checking bench of the beacon field builder
module test_beacon_field_builder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fail = 1'b0, assoc = 1'b0;
  logic obs_v = 1'b0, breq = 1'b0, ack = 1'b0, rxv = 1'b0, stall = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] hops = 4'h0;
  logic [15:0] obs = 16'h0, rxfc = 16'h0, cost;
  logic txv, txl, ackr, rxb, rxd, ready;
  logic [7:0] txb, frames;
  logic [103:0] frame;
  int n_fail = 0, cmp_count = 0;
  // clock of 25 ns
  always #12.5 clk = ~clk;
  beacon_field_builder u_beacon_field_builder (
    .CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .COORD_FAIL_I(fail),
    .ASSOC_I(assoc), .HOP_COUNT_I(hops), .OBS_COST_VALID_I(obs_v), .OBS_COST_I(obs),
    .BEACON_REQ_I(breq), .TX_READY_I(ready), .TX_VALID_O(txv), .TX_BYTE_O(txb),
    .TX_LAST_O(txl), .ACK_NEEDED_I(ack), .PHY_ACK_REQ_O(ackr), .RX_FC_VALID_I(rxv),
    .RX_FC_I(rxfc), .RX_IS_BEACON_O(rxb), .RX_FC_DONE_O(rxd), .COORD_COST_O(cost));
  beacon_sink_model u_beacon_sink_model (.clk_i(clk), .rst_i(rst), .stall_i(stall),
    .valid_i(txv), .byte_i(txb), .last_i(txl), .ready_o(ready), .frame_o(frame),
    .frames_o(frames));
  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, "reg read");
    @(posedge clk);
    #1 chk(rdata, 32'h0, "read end");
  endtask
  // one cost event, cost looked at one cycle later
  task automatic cost_ev(input logic f, a, v, input logic [15:0] c, e);
    @(posedge clk);
    fail <= f; assoc <= a; obs_v <= v; obs <= c;
    @(posedge clk);
    fail <= 1'b0; assoc <= 1'b0; obs_v <= 1'b0;
    #1 chk(cost, e, "cost");
  endtask
  task automatic s_reset();
    logic [4:0] a[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
    logic [31:0] e[7] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h8, 32'hFFFF, 32'h0, 32'h0};
    foreach (a[i]) rreg(a[i], e[i]);
  endtask
  task automatic s_ack_rx();
    logic [15:0] fc[3] = '{16'h3000, 16'h0001, 16'h2048};
    logic ex[3] = '{1'b1, 1'b0, 1'b1};
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1 chk(ackr, 1, "ack");
    @(posedge clk);
    #1 chk(ackr, 0, "ack end");
    foreach (fc[i]) begin
      @(posedge clk);
      rxv <= 1'b1; rxfc <= fc[i];
      @(posedge clk);
      rxv <= 1'b0;
      #1 chk(rxd, 1, "rx done");
      chk(rxb, ex[i], "rx type");
    end
  endtask
  task automatic s_cost();
    cost_ev(0, 0, 1, 16'h0100, 16'h0100);
    cost_ev(0, 0, 1, 16'h0100, 16'h0100);
    cost_ev(0, 0, 1, 16'h0200, 16'h0100);
    cost_ev(0, 0, 1, 16'h00FF, 16'h00FF);
    cost_ev(1, 1, 1, 16'h0001, 16'hFFFF);
    cost_ev(0, 1, 1, 16'h0001, 16'h7FFF);
    cost_ev(0, 0, 1, 16'h0010, 16'h0010);
    wreg(5'h0C, 32'h3);
    hops <= 4'h3;
    cost_ev(0, 0, 1, 16'h0005, 16'h7FFF);
    rreg(5'h18, 32'h2);
    hops <= 4'h0;
    wreg(5'h10, 32'h1234);
    rreg(5'h10, 32'h7FFF);
    wreg(5'h00, 32'h1);
    cost_ev(1, 1, 1, 16'h0001, 16'h0000);
    wreg(5'h00, 32'h2);
    cost_ev(0, 1, 0, 16'h0000, 16'h7FFF);
    cost_ev(0, 0, 1, 16'h12C4, 16'h12C4);
  endtask
  // beacon with a second request while busy, which must be ignored
  task automatic s_beacon(input logic st, input logic [7:0] sq, input logic [1:0] ct,
                          input logic [15:0] c);
    logic [103:0] e;
    logic [7:0] n0;
    int k;
    e = {c[7:0], c[15:8], 16'h0, ct[1], ct[0], 6'h00, 8'h00, 16'h1234, 16'hABCD, 8'h00, 8'h80,
         8'h00};
    e[23:16] = sq;
    wreg(5'h14, {24'h0, sq});
    @(posedge clk);
    stall <= st; breq <= 1'b1; n0 = frames;
    @(posedge clk);
    breq <= 1'b0;
    rreg(5'h18, 32'h1);
    @(posedge clk);
    breq <= 1'b1;
    @(posedge clk);
    breq <= 1'b0;
    for (k = 0; k < 200 && frames == n0; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      n_fail++;
      $display("[FAIL] %0t beacon timeout", $time);
      stop_test();
    end
    for (k = 0; k < 13; k++) chk(frame[8*k +: 8], e[8*k +: 8], "byte");
    @(posedge clk);
    #1 chk(txv, 0, "frame end");
    chk(frames, n0 + 8'h01, "frames");
    rreg(5'h14, {24'h0, sq + 8'h01});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_ack_rx();
    s_cost();
    wreg(5'h04, 32'hABCD);
    wreg(5'h08, 32'h1234);
    s_beacon(1'b1, 8'hFE, 2'b10, 16'h12C4);
    s_beacon(1'b0, 8'hFF, 2'b10, 16'h12C4);
    wreg(5'h00, 32'h1);
    s_beacon(1'b1, 8'h00, 2'b01, 16'h0000);
    stop_test();
  end
endmodule // test_beacon_field_builder
